// *** rtl/tlviu_top.sv ***
// two-level vectored interrupt unit with apb register access
//
// What this block does
// - fourteen sources: ext 0-9, three timers, uart
// - two nested priority levels with preemption
// - port 1 pins are ext requests 2-9
// - enabled port-1 request wakes from power-down
// - polarity bit 1 high, 0 low
// - hardware sets flag, only software clears it
// - port-1 level held one machine cycle
// - service starts no earlier than next cycle
// - each source has its own fixed vector
// - disabled source is never serviced
// - global enable gates every source
// - enable bit 0 disables, 1 enables
// - priority bit 0 low, 1 high
// - high request beats simultaneous low request
// - low routine preempted only by high
// - high routine is never interrupted
// - main priority map, bits 7 and 5 unused
// - polarity bit n controls ext n+2
`timescale 1ns/100ps
module tlviu_top
    import tlviu_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [1:0] i_ext_n,
    input wire logic [7:0] i_port1,
    input wire logic [2:0] i_timer_req,
    input wire logic i_uart_req,
    input wire logic i_irq_ack,
    input wire logic i_irq_return,
    input wire logic i_power_down,
    output tlviu_core_req_t o_core_req,
    output logic o_wake
);

    ////////////////////////////////////////////////////////////////////
    // helper functions

    // vector of a source by its arbitration index
    function automatic logic [15:0] vec_of(input logic [3:0] idx);
        logic [15:0] v;
        v = VEC_X9;
        unique case (idx)
            4'h0: v = VEC_X0;
            4'h1: v = VEC_X5;
            4'h2: v = VEC_T0;
            4'h3: v = VEC_T2;
            4'h4: v = VEC_X6;
            4'h5: v = VEC_X1;
            4'h6: v = VEC_X2;
            4'h7: v = VEC_X7;
            4'h8: v = VEC_T1;
            4'h9: v = VEC_X3;
            4'ha: v = VEC_X8;
            4'hb: v = VEC_S0;
            4'hc: v = VEC_X4;
            4'hd: v = VEC_X9;
            default: v = VEC_X9;
        endcase
        return v;
    endfunction

    // lowest set bit wins, that is the earliest in the fixed order
    function automatic logic [3:0] first_of(input logic [NSRC-1:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (m[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [9:0] s1_reg;
    logic [9:0] s2_reg;
    logic [9:0] s3_reg;
    logic [9:0] pin_reg;

    // three stages; a change counts once stages two and three agree
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1_reg <= 10'h3ff;
            s2_reg <= 10'h3ff;
            s3_reg <= 10'h3ff;
            pin_reg <= 10'h3ff;
        end else begin
            s1_reg <= {i_ext_n, i_port1};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < 10; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    pin_reg[i] <= s3_reg[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] en_main_reg;
    logic [7:0] pri_main_reg;
    logic [7:0] flags_reg;
    logic [7:0] ext_en_reg;
    logic [7:0] pol_reg;
    logic [7:0] ext_pri_reg;
    logic [7:0] act_d_reg;
    logic [7:0] p1_act;
    logic [7:0] p1_set;
    logic wr;
    logic rd_setup;
    logic [7:0] idx;
    logic mapped;

    assign idx = i_paddr[9:2];
    assign wr = i_psel && i_penable && i_pwrite;
    assign rd_setup = i_psel && !i_penable;
    assign mapped = (i_paddr[11:10] == 2'b00) &&
        (idx == IDX_EN_MAIN || idx == IDX_PRI_MAIN ||
         idx == IDX_FLAGS || idx == IDX_EXT_EN ||
         idx == IDX_EXT_POL || idx == IDX_EXT_PRI ||
         idx == IDX_STATUS);

    // plain software registers, written in the access phase
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            en_main_reg <= RST_BYTE;
            pri_main_reg <= RST_BYTE;
            ext_en_reg <= RST_BYTE;
            pol_reg <= RST_BYTE;
            ext_pri_reg <= RST_BYTE;
        end else if (wr && mapped) begin
            unique case (idx)
                IDX_EN_MAIN: en_main_reg <= i_pwdata[7:0];
                IDX_PRI_MAIN:
                    pri_main_reg <= i_pwdata[7:0] & PRI_MAIN_MASK;
                IDX_EXT_EN: ext_en_reg <= i_pwdata[7:0];
                IDX_EXT_POL: pol_reg <= i_pwdata[7:0];
                IDX_EXT_PRI: ext_pri_reg <= i_pwdata[7:0];
                default: ;
            endcase
        end
    end

    // polarity: 1 means active high, 0 active low
    assign p1_act = ~(pin_reg[7:0] ^ pol_reg);
    // active now and one cycle before: a full machine cycle held
    assign p1_set = p1_act & act_d_reg & ext_en_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act_d_reg <= RST_BYTE;
        end else begin
            act_d_reg <= p1_act;
        end
    end

    // a set in the cycle of a software write wins over the clear
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags_reg <= RST_BYTE;
        end else if (wr && idx == IDX_FLAGS && mapped) begin
            flags_reg <= i_pwdata[7:0] | p1_set;
        end else begin
            flags_reg <= flags_reg | p1_set;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sources in fixed arbitration order

    logic [NSRC-1:0] req_ord;
    logic [NSRC-1:0] en_ord;
    logic [NSRC-1:0] pri_ord;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] hi_pend;
    logic [NSRC-1:0] lo_pend;
    logic [7:0] m;
    logic [7:0] p;

    assign m = en_main_reg;
    assign p = pri_main_reg;
    // port-1 flags feed arbitration, so service trails recognition
    assign req_ord = {flags_reg[7], flags_reg[2], i_uart_req,
        flags_reg[6], flags_reg[1], i_timer_req[1], flags_reg[5],
        flags_reg[0], ~pin_reg[9], flags_reg[4], i_timer_req[2],
        i_timer_req[0], flags_reg[3], ~pin_reg[8]};
    assign en_ord = {ext_en_reg[7], ext_en_reg[2], m[UART_BIT],
        ext_en_reg[6], ext_en_reg[1], m[T1_BIT], ext_en_reg[5],
        ext_en_reg[0], m[X1_BIT], ext_en_reg[4], m[T2_BIT],
        m[T0_BIT], ext_en_reg[3], m[X0_BIT]};
    assign pri_ord = {ext_pri_reg[7], ext_pri_reg[2], p[UART_BIT],
        ext_pri_reg[6], ext_pri_reg[1], p[T1_BIT], ext_pri_reg[5],
        ext_pri_reg[0], p[X1_BIT], ext_pri_reg[4], p[T2_BIT],
        p[T0_BIT], ext_pri_reg[3], p[X0_BIT]};
    assign pend = req_ord & en_ord;
    assign hi_pend = pend & pri_ord;
    assign lo_pend = pend & ~pri_ord;

    ////////////////////////////////////////////////////////////////////
    // nesting and arbitration

    logic act_hi_reg;
    logic act_lo_reg;
    logic gie;
    logic can_hi;
    logic can_lo;
    logic take;
    tlviu_core_req_t req_reg;
    tlviu_core_req_t req_next;

    assign gie = en_main_reg[GIE_BIT];
    assign can_hi = gie && !act_hi_reg;
    assign can_lo = can_hi && !act_lo_reg;
    assign take = i_irq_ack && req_reg.valid;

    // high level first, then fixed order inside the level
    always_comb begin
        req_next = '0;
        if (can_hi && |hi_pend) begin
            req_next.valid = 1'b1;
            req_next.high = 1'b1;
            req_next.src = first_of(hi_pend);
        end else if (can_lo && |lo_pend) begin
            req_next.valid = 1'b1;
            req_next.src = first_of(lo_pend);
        end
        req_next.vector = vec_of(req_next.src);
        if (take) begin
            req_next = '0;
        end
    end

    // dropped for a cycle after an ack so the core sees a clean edge
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_reg <= '0;
        end else begin
            req_reg <= req_next;
        end
    end

    // in-service levels; a return ends the highest one running
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            act_hi_reg <= 1'b0;
            act_lo_reg <= 1'b0;
        end else if (take) begin
            if (req_reg.high) begin
                act_hi_reg <= 1'b1;
            end else begin
                act_lo_reg <= 1'b1;
            end
        end else if (i_irq_return) begin
            if (act_hi_reg) begin
                act_hi_reg <= 1'b0;
            end else begin
                act_lo_reg <= 1'b0;
            end
        end
    end

    assign o_core_req = req_reg;

    ////////////////////////////////////////////////////////////////////
    // wake-up from power-down

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= i_power_down && |p1_set;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb read path; data latched in setup, answer with no wait

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            o_prdata <= 32'h0000_0000;
            if (mapped) begin
                unique case (idx)
                    IDX_EN_MAIN: o_prdata[7:0] <= en_main_reg;
                    IDX_PRI_MAIN: o_prdata[7:0] <= pri_main_reg;
                    IDX_FLAGS: o_prdata[7:0] <= flags_reg;
                    IDX_EXT_EN: o_prdata[7:0] <= ext_en_reg;
                    IDX_EXT_POL: o_prdata[7:0] <= pol_reg;
                    IDX_EXT_PRI: o_prdata[7:0] <= ext_pri_reg;
                    default: o_prdata[7:0] <= {act_hi_reg, act_lo_reg,
                        req_reg.valid, req_reg.high, req_reg.src};
                endcase
            end
        end
    end

    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !mapped;

    ////////////////////////////////////////////////////////////////////
    // checks

    sequence s_p1_held;
        |p1_set;
    endsequence

    sequence s_no_flag_write;
        !(wr && idx == IDX_FLAGS);
    endsequence

    property p_gated(logic c);
        @(posedge i_core_clk) disable iff (!i_rst_n)
        req_reg.valid |-> $past(c);
    endproperty

    a_global_gate: assert property (p_gated(gie))
        else $error("request raised with global enable off");
    a_high_no_nest: assert property (p_gated(!act_hi_reg))
        else $error("request raised inside a high routine");
    a_low_preempt: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n)
        req_reg.valid && !req_reg.high |-> !$past(act_lo_reg))
        else $error("low request preempted a low routine");
    a_high_wins: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n)
        can_hi && |hi_pend && !take |=> req_reg.valid && req_reg.high)
        else $error("high request did not win");
    a_flag_sticky: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n)
        s_no_flag_write |=> (flags_reg & $past(flags_reg)) ==
            $past(flags_reg))
        else $error("request flag cleared by hardware");
    a_flag_cause: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n)
        ##1 $past(!(wr && idx == IDX_FLAGS)) |->
            (flags_reg & ~$past(flags_reg) & ~$past(p1_set)) == 8'h00)
        else $error("flag set without a held active level");
    a_vector_map: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n)
        req_reg.valid |-> req_reg.vector == vec_of(req_reg.src))
        else $error("vector does not match source");
    a_enable_gate: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n)
        req_reg.valid |->
            |($past(en_ord) & (14'h0001 << req_reg.src)))
        else $error("disabled source requested");
    a_wake_on_req: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n)
        i_power_down ##0 s_p1_held |=> o_wake)
        else $error("no wake on enabled port request");
    a_p1_late: assert property (@(posedge i_core_clk)
        disable iff (!i_rst_n)
        req_reg.valid && req_reg.src == 4'h6 |-> $past(flags_reg[0]))
        else $error("port request serviced too early");

endmodule

// *** rtl/tlviu_pkg.sv ***
// shared constants and carrier types of the interrupt unit
package tlviu_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_EN_MAIN = 8'ha8;
    localparam logic [7:0] IDX_PRI_MAIN = 8'hb8;
    localparam logic [7:0] IDX_FLAGS = 8'hc0;
    localparam logic [7:0] IDX_EXT_EN = 8'he8;
    localparam logic [7:0] IDX_EXT_POL = 8'he9;
    localparam logic [7:0] IDX_EXT_PRI = 8'hf8;
    localparam logic [7:0] IDX_STATUS = 8'hd0;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // field positions in the main enable register
    localparam int GIE_BIT = 7;
    localparam int T2_BIT = 6;
    localparam int RSV_BIT = 5;
    localparam int UART_BIT = 4;
    localparam int T1_BIT = 3;
    localparam int X1_BIT = 2;
    localparam int T0_BIT = 1;
    localparam int X0_BIT = 0;
    // main priority register has no bits 7 and 5
    localparam logic [7:0] PRI_MAIN_MASK = 8'h5f;
    localparam int NSRC = 14;
    // vector table in fixed arbitration order, highest first
    localparam logic [15:0] VEC_X0 = 16'h0003;
    localparam logic [15:0] VEC_X5 = 16'h0053;
    localparam logic [15:0] VEC_T0 = 16'h000b;
    localparam logic [15:0] VEC_T2 = 16'h002b;
    localparam logic [15:0] VEC_X6 = 16'h005b;
    localparam logic [15:0] VEC_X1 = 16'h0013;
    localparam logic [15:0] VEC_X2 = 16'h003b;
    localparam logic [15:0] VEC_X7 = 16'h0063;
    localparam logic [15:0] VEC_T1 = 16'h001b;
    localparam logic [15:0] VEC_X3 = 16'h0043;
    localparam logic [15:0] VEC_X8 = 16'h006b;
    localparam logic [15:0] VEC_S0 = 16'h0023;
    localparam logic [15:0] VEC_X4 = 16'h004b;
    localparam logic [15:0] VEC_X9 = 16'h0073;

    // request presented to the processor core
    typedef struct packed {
        logic valid;
        logic high;
        logic [3:0] src;
        logic [15:0] vector;
    } tlviu_core_req_t;
endpackage

// *** sim/tlviu_core_model.sv ***
// core side model: takes presented requests after a delay
`timescale 1ns/100ps
module tlviu_core_model
    import tlviu_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire tlviu_core_req_t i_core_req,
    input wire logic i_hold,
    input wire logic [3:0] i_ack_delay,
    output logic o_irq_ack,
    output logic [15:0] o_last_vec,
    output logic [7:0] o_ack_cnt
);
    logic [3:0] wait_reg;
    // a held core never acks, so requests stay pending
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_reg <= 4'h0;
            o_irq_ack <= 1'b0;
        end else if (i_core_req.valid && !o_irq_ack && !i_hold) begin
            o_irq_ack <= (wait_reg >= i_ack_delay);
            wait_reg <= (wait_reg >= i_ack_delay) ? 4'h0 : wait_reg + 4'h1;
        end else begin
            o_irq_ack <= 1'b0;
            wait_reg <= 4'h0;
        end
    end
    // record the vector at the accepting edge only
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_last_vec <= 16'h0000;
            o_ack_cnt <= 8'h00;
        end else if (o_irq_ack && i_core_req.valid) begin
            o_last_vec <= i_core_req.vector;
            o_ack_cnt <= o_ack_cnt + 8'h01;
        end
    end
endmodule

// *** sim/test_two_level_vectored_interrupt_unit.sv ***
// self-checking bench of the interrupt unit
`timescale 1ns/100ps
module test_two_level_vectored_interrupt_unit;
    import tlviu_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] ext_n;
    logic [7:0] port1, pol, d;
    logic [2:0] tmr;
    logic uart, ack, ret, pdn, wake, hold;
    logic [3:0] dly;
    logic [15:0] lvec;
    logic [7:0] acnt;
    tlviu_core_req_t req;
    int error_cnt, n_compared, cyc;
    // arbitration order: port flag in bit 3, bit position below
    localparam logic [3:0] MAP [14] = '{4'h0, 4'hb, 4'h1, 4'h6, 4'hc,
        4'h2, 4'h8, 4'hd, 4'h3, 4'h9, 4'he, 4'h4, 4'ha, 4'hf};
    localparam logic [15:0] VEC [14] = '{16'h0003, 16'h0053, 16'h000b,
        16'h002b, 16'h005b, 16'h0013, 16'h003b, 16'h0063, 16'h001b,
        16'h0043, 16'h006b, 16'h0023, 16'h004b, 16'h0073};
    localparam logic [7:0] RW [5] = '{IDX_EN_MAIN, IDX_PRI_MAIN,
        IDX_EXT_EN, IDX_EXT_POL, IDX_EXT_PRI};

    tlviu_top DUT (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_ext_n(ext_n), .i_port1(port1),
        .i_timer_req(tmr), .i_uart_req(uart), .i_irq_ack(ack),
        .i_irq_return(ret), .i_power_down(pdn), .o_core_req(req),
        .o_wake(wake));
    tlviu_core_model core (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_core_req(req), .i_hold(hold), .i_ack_delay(dly),
        .o_irq_ack(ack), .o_last_vec(lvec), .o_ack_cnt(acnt));

    ////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] idx,
                       input logic [7:0] v);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h00_0000, v};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] fold(input logic [13:0] m,
                                        input logic pt);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 14; i++)
            if (MAP[i][3] == pt && m[i]) r[MAP[i][2:0]] = 1'b1;
        return r;
    endfunction
    function automatic int winner(input logic [13:0] m, hi);
        for (int i = 0; i < 14; i++) if (m[i] && hi[i]) return i;
        for (int i = 0; i < 14; i++) if (m[i]) return i;
        return -1;
    endfunction
    // active pins sit at the polarity level, idle ones opposite
    task automatic drive(input logic [13:0] m);
        logic [7:0] q;
        q = fold(m, 1'b0);
        port1 <= ~(fold(m, 1'b1) ^ pol);
        ext_n <= ~{q[2], q[0]};
        tmr <= {q[6], q[3], q[1]};
        uart <= q[4];
    endtask
    task automatic idle_all(input logic [7:0] np);
        apb(1'b1, IDX_EN_MAIN, 8'h00);
        apb(1'b1, IDX_EXT_EN, 8'h00);
        drive(14'h0000);
        pol = np;
        apb(1'b1, IDX_EXT_POL, np);
        drive(14'h0000);
        repeat (6) @(posedge clk);
        apb(1'b1, IDX_FLAGS, 8'h00);
    endtask
    // reserved enable bit stays zero: no source maps to bit 5
    task automatic cfg(input logic [13:0] en, hi, input logic g);
        logic [7:0] f;
        f = fold(en, 1'b0);
        apb(1'b1, IDX_PRI_MAIN, fold(hi, 1'b0));
        apb(1'b1, IDX_EXT_PRI, fold(hi, 1'b1));
        apb(1'b1, IDX_EXT_EN, fold(en, 1'b1));
        apb(1'b1, IDX_EN_MAIN, {g, f[6:0]});
    endtask
    task automatic run_arb(input logic [13:0] en, pe, hi, input logic g,
                           input logic [7:0] np);
        int w;
        idle_all(np);
        cfg(en, hi, g);
        drive(pe);
        repeat (10) @(posedge clk);
        w = g ? winner(pe & en, hi) : -1;
        chk("valid", 32'(w >= 0), 32'(req.valid));
        if (w >= 0) begin
            chk("vector", 32'(VEC[w]), 32'(req.vector));
            chk("src", 32'(w), 32'(req.src));
            chk("high", 32'(hi[w]), 32'(req.high));
        end
        chk("wake", 32'h0, 32'(wake));
        drive(14'h0000);
        repeat (6) @(posedge clk);
        apb(1'b0, IDX_FLAGS, 8'h00);
        chk("flags", 32'(fold(pe & en, 1'b1)), rd);
    endtask
    task automatic nest(input logic [13:0] m, input logic [7:0] n,
                        input logic [15:0] v);
        drive(m);
        repeat (14) @(posedge clk);
        chk("acks", 32'(n), 32'(acnt));
        chk("taken", 32'(v), 32'(lvec));
    endtask
    task automatic pop();
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        {clk, rst_n, psel, penable, pwrite, uart, ret, pdn} = 8'h00;
        {paddr, pwdata, tmr, pol, dly} = '0;
        error_cnt = 0;
        n_compared = 0;
        cyc = 0;
        ext_n = 2'b11;
        port1 = 8'hff;
        hold = 1'b1;
        rd = $urandom(56238);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset values, unmapped place, read back
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, RW[i], 8'h00);
            chk("reset", 32'h0, rd);
        end
        apb(1'b0, 8'h10, 8'h00);
        chk("slverr", 32'h1, 32'(er));
        chk("unmapped", 32'h0, rd);
        repeat (3) for (int i = 0; i < 5; i++) begin
            d = 8'($urandom);
            d[5] = (i == 0) ? 1'b0 : d[5];
            apb(1'b1, RW[i], d);
            apb(1'b0, RW[i], 8'h00);
            chk("readback", (i == 1) ? 32'(d & 8'h5f) : 32'(d), rd);
        end
        // each source alone, then random mixes
        for (int i = 0; i < 14; i++)
            run_arb(14'h3fff, 14'(1 << i), 14'($urandom), 1'b1, 8'($urandom));
        repeat (20)
            run_arb(14'($urandom), 14'($urandom), 14'($urandom),
                    $urandom_range(7) != 0, 8'($urandom));
        // a one-cycle pulse is too short, two cycles are enough
        for (int n = 1; n < 3; n++) begin
            idle_all(8'hff);
            cfg(14'h0040, 14'h0000, 1'b1);
            port1 <= 8'h01;
            repeat (n) @(posedge clk);
            port1 <= 8'h00;
            repeat (8) @(posedge clk);
            apb(1'b0, IDX_FLAGS, 8'h00);
            chk("pulse", 32'(n == 2), rd);
        end
        // wake from power-down
        pdn <= 1'b1;
        idle_all(8'hff);
        cfg(14'h0040, 14'h0000, 1'b1);
        drive(14'h0040);
        repeat (10) @(posedge clk);
        chk("wake", 32'h1, 32'(wake));
        pdn <= 1'b0;
        // nesting with a live core, prompt or slow
        idle_all(8'h00);
        cfg(14'h0125, 14'h0101, 1'b1);
        hold <= 1'b0;
        dly <= 4'($urandom_range(5));
        nest(14'h0004, 8'd1, 16'h000b);
        nest(14'h0020, 8'd1, 16'h000b);
        nest(14'h0021, 8'd2, 16'h0003);
        nest(14'h0120, 8'd2, 16'h0003);
        pop();
        nest(14'h0120, 8'd3, 16'h001b);
        pop();
        nest(14'h0020, 8'd3, 16'h001b);
        pop();
        nest(14'h0020, 8'd4, 16'h0013);
        // low routine running, no high one, nothing presented
        apb(1'b0, IDX_STATUS, 8'h00);
        chk("status", 32'h0000_0040, rd);
        close_out();
    end
endmodule
